// File: wsd_map.svh
// constants for the watch display and time-setting control
// Operation
// - second display closure before hours-minutes timeout shows date 1.25 s
// - date stays shown while display switch is held closed
// - date counts 1 to 31 with leading zero blanked
// - date held, set closed: date advances at 2 Hz until set opens
// - seconds, minutes and hours keep counting during date setting
// - set alone shows hours-minutes and advances hours at 2 Hz
// - both closed: hours-minutes shown, minutes advance 2 Hz after 0.75-1.0 s
// - set opens with display held: hold, blink 0.25 s on 0.75 s off
// - seconds forced to 00 during minute setting and hold
// - both switches open returns all counters to normal counting
// - short set closure with display held clears seconds, minutes unchanged
// - counter being set never carries into the next higher counter
// - display and set debounced on closure and release, 20 ms bounce
// - digit on-time from duty-select and dim: 7/8, 2/8, 4/8, 1/8
// - dim left unconnected reads as logic 1
// - 4096 Hz square wave at 50 percent duty on tuning output
// - test high: pad outputs 4 Hz tick; test low: pad input replaces tick
// - lamp test low lights every segment, still gated by digit duty
// - display closure shows hours-minutes for 1.25 s
// - four digits multiplexed from 1024 Hz, each digit a quarter of time
// - date or hours in digits 1-2, minutes or seconds in digits 3-4
// - hours count 1 to 12, AM on segment f of digit 1, zero blanked
`ifndef WSD_MAP_SVH
`define WSD_MAP_SVH

`define WSD_PCLK_HZ 125000000
`define WSD_TICK_HZ 8192
`define WSD_DEB_MS 20
`define WSD_DEB_TICKS ((`WSD_DEB_MS * `WSD_TICK_HZ + 999) / 1000)
`define WSD_QTR_MS 250
`define WSD_SHOW_MS 1250
`define WSD_SHOW_QTRS (`WSD_SHOW_MS / `WSD_QTR_MS)
`define WSD_MINSET_MS 750
`define WSD_MINSET_QTRS (`WSD_MINSET_MS / `WSD_QTR_MS)

`define WSD_CTRL_OFS 12'h000
`define WSD_TIME_OFS 12'h004
`define WSD_STAT_OFS 12'h008
`define WSD_CTRL_OVR_BIT 0
`define WSD_CTRL_SEL_LSB 1
`define WSD_TIME_SEC_LSB 0
`define WSD_TIME_MIN_LSB 8
`define WSD_TIME_HR_LSB 16
`define WSD_TIME_PM_BIT 20
`define WSD_TIME_DATE_LSB 24
`define WSD_STAT_DB_LSB 0
`define WSD_STAT_MODE_LSB 4

`define WSD_HR_RST 4'hc
`define WSD_DATE_RST 5'h01

`endif

// File: wsd_pkg.sv
// types for the watch display and time-setting control
package wsd_pkg;

    typedef enum logic [2:0] {
        M_OFF  = 3'b000,
        M_HM   = 3'b001,
        M_SEC  = 3'b010,
        M_DATE = 3'b011,
        M_DSET = 3'b100,
        M_HSET = 3'b101,
        M_MSET = 3'b110,
        M_HOLD = 3'b111
    } wsd_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wsd_apb_req_t;

    typedef struct packed {
        logic [3:0] digit_en;
        logic [6:0] seg;
        logic colon;
    } wsd_disp_t;

    typedef struct packed {
        logic [15:0] pre;
        logic [10:0] div;
        logic pad_prev;
        logic [1:0] db;
        logic [1:0][7:0] dcnt;
        logic [1:0] q4;
        logic [2:0] both_q;
        logic [2:0] tmr;
        wsd_mode_t mode;
        logic [5:0] sec;
        logic [5:0] min;
        logic [3:0] hr;
        logic pm;
        logic [4:0] date;
        logic [2:0] ctrl;
        logic [31:0] prdata;
        logic pslverr;
        wsd_disp_t disp;
    } wsd_state_t;

endpackage

// File: wsd_watch_ctrl.sv
// watch display, time setting and brightness control with apb status access
`include "wsd_map.svh"

module wsd_watch_ctrl #(
    parameter int TICK_CYC = `WSD_PCLK_HZ / `WSD_TICK_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire wsd_pkg::wsd_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic disp_sw,
    input wire logic set_sw,
    input wire logic dtcycl,
    input wire logic dim,
    input wire logic lamp_n,
    input wire logic test_n,
    input wire logic tick_monitor_inject_pad_i,
    output logic tick_monitor_inject_pad_o,
    output logic tick_monitor_inject_pad_oe,
    output logic osc_tune_4096,
    output wsd_pkg::wsd_disp_t disp
);

    localparam wsd_pkg::wsd_state_t RST = '{
        pre: '0, div: '0, pad_prev: 1'b0, db: '0, dcnt: '0, q4: '0,
        both_q: '0, tmr: '0, mode: wsd_pkg::M_OFF, sec: '0, min: '0,
        hr: `WSD_HR_RST, pm: 1'b0, date: `WSD_DATE_RST, ctrl: '0,
        prdata: '0, pslverr: 1'b0, disp: '0};
    localparam logic [7:0] DEB_LAST = 8'(`WSD_DEB_TICKS - 1);
    localparam logic [2:0] SHOW_Q = 3'(`WSD_SHOW_QTRS);
    localparam logic [2:0] MIN_Q = 3'(`WSD_MINSET_QTRS);

    wsd_pkg::wsd_state_t r_reg;
    wsd_pkg::wsd_state_t r_next;

    logic t8k;
    logic qt;
    logic adv2;
    logic adv_min;
    logic sec_carry;
    logic min_carry;
    logic hr_carry;
    logic d_rise;
    logic d_lvl;
    logic s_lvl;
    logic [1:0] raw;
    logic [4:0] hstep;
    logic [7:0] lbcd;
    logic [7:0] rbcd;
    logic [3:0] dval;
    logic dblank;
    logic [6:0] sg;
    logic [2:0] ontime;
    logic [1:0] bright;
    logic visible;
    logic active;
    logic hm_mode;
    logic [31:0] rd;

    // 12-hour step: returns {pm, hour}
    function automatic logic [4:0] hr_step(input logic [3:0] h, input logic p);
        logic [4:0] res;
        res = {p, 4'h1};
        if (h == 4'hb) begin
            res = {~p, 4'hc};
        end else if (h != 4'hc) begin
            res = {p, 4'(h + 4'h1)};
        end
        return res;
    endfunction

    function automatic logic [7:0] to_bcd(input logic [5:0] v);
        return {4'(v / 6'h0a), 4'(v % 6'h0a)};
    endfunction

    // segment pattern, bit order g f e d c b a
    function automatic logic [6:0] seg7(input logic [3:0] v);
        logic [6:0] s;
        case (v)
            4'h0: s = 7'h3f;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5b;
            4'h3: s = 7'h4f;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6d;
            4'h6: s = 7'h7d;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7f;
            4'h9: s = 7'h6f;
            default: s = 7'h00;
        endcase
        return s;
    endfunction

    // whole next-state computation
    always_comb begin
        r_next = r_reg;
        // time base: one 8192 Hz tick, everything else divides it
        t8k = (r_reg.pre == 16'(TICK_CYC - 1));
        r_next.pre = t8k ? 16'h0000 : 16'(r_reg.pre + 16'h0001);
        if (t8k) begin
            r_next.div = 11'(r_reg.div + 11'h001);
        end
        r_next.pad_prev = tick_monitor_inject_pad_i;
        // pad input replaces the internal 4 Hz tick in test
        qt = test_n ? (t8k && r_reg.div == 11'h7ff)
                    : (tick_monitor_inject_pad_i && !r_reg.pad_prev);

        // debounce: a new level is taken only after 20 ms of stability
        raw = {set_sw, disp_sw};
        for (int i = 0; i < 2; i++) begin
            if (raw[i] == r_reg.db[i]) begin
                r_next.dcnt[i] = 8'h00;
            end else if (t8k) begin
                if (r_reg.dcnt[i] == DEB_LAST) begin
                    r_next.db[i] = raw[i];
                    r_next.dcnt[i] = 8'h00;
                end else begin
                    r_next.dcnt[i] = 8'(r_reg.dcnt[i] + 8'h01);
                end
            end
        end
        d_lvl = r_reg.db[0];
        s_lvl = r_reg.db[1];
        d_rise = r_next.db[0] && !r_reg.db[0];

        // quarter-second bookkeeping; set pulses derive from the same tick
        adv2 = qt && r_reg.q4[0];
        if (qt) begin
            r_next.q4 = 2'(r_reg.q4 + 2'h1);
            if (r_reg.tmr != 3'h0) begin
                r_next.tmr = 3'(r_reg.tmr - 3'h1);
            end
            if (r_reg.both_q < 3'h4) begin
                r_next.both_q = 3'(r_reg.both_q + 3'h1);
            end else begin
                r_next.both_q = (r_reg.both_q == 3'h4) ? 3'h5 : 3'h4;
            end
        end
        // first minute step after 4 quarter ticks: 0.75 to 1.0 s of hold
        adv_min = qt && (r_reg.both_q == MIN_Q || r_reg.both_q == 3'h5);

        // switch-driven mode sequencing
        case (r_reg.mode)
            wsd_pkg::M_OFF: begin
                if (d_rise) begin
                    r_next.mode = wsd_pkg::M_HM;
                    r_next.tmr = SHOW_Q;
                end else if (s_lvl && !d_lvl) begin
                    r_next.mode = wsd_pkg::M_HSET;
                end
            end
            wsd_pkg::M_HM: begin
                if (s_lvl) begin
                    r_next.mode = d_lvl ? wsd_pkg::M_MSET : wsd_pkg::M_HSET;
                    r_next.both_q = 3'h0;
                end else if (d_rise) begin
                    r_next.mode = wsd_pkg::M_DATE;
                    r_next.tmr = SHOW_Q;
                end else if (r_reg.tmr == 3'h0) begin
                    r_next.mode = d_lvl ? wsd_pkg::M_SEC : wsd_pkg::M_OFF;
                end
            end
            wsd_pkg::M_SEC: begin
                if (s_lvl) begin
                    r_next.mode = wsd_pkg::M_MSET;
                    r_next.both_q = 3'h0;
                end else if (!d_lvl) begin
                    r_next.mode = wsd_pkg::M_OFF;
                end
            end
            wsd_pkg::M_DATE: begin
                if (d_lvl && s_lvl) begin
                    r_next.mode = wsd_pkg::M_DSET;
                end else if (r_reg.tmr == 3'h0 && !d_lvl) begin
                    r_next.mode = wsd_pkg::M_OFF;
                end
            end
            wsd_pkg::M_DSET: begin
                if (!d_lvl) begin
                    r_next.mode = wsd_pkg::M_OFF;
                end else if (!s_lvl) begin
                    r_next.mode = wsd_pkg::M_DATE;
                end
            end
            wsd_pkg::M_HSET: begin
                if (d_lvl) begin
                    r_next.mode = wsd_pkg::M_MSET;
                    r_next.both_q = 3'h0;
                end else if (!s_lvl) begin
                    r_next.mode = wsd_pkg::M_OFF;
                end
            end
            wsd_pkg::M_MSET: begin
                // short closures leave here before adv_min ever fires
                if (!s_lvl) begin
                    r_next.mode = d_lvl ? wsd_pkg::M_HOLD : wsd_pkg::M_OFF;
                end else if (!d_lvl) begin
                    r_next.mode = wsd_pkg::M_HSET;
                end
            end
            wsd_pkg::M_HOLD: begin
                if (s_lvl) begin
                    r_next.mode = wsd_pkg::M_MSET;
                    r_next.both_q = 3'h0;
                end else if (!d_lvl) begin
                    r_next.mode = wsd_pkg::M_OFF;
                end
            end
            default: begin
                r_next.mode = wsd_pkg::M_OFF;
            end
        endcase

        // seconds, held at zero while minutes are set or in hold
        sec_carry = 1'b0;
        if (r_reg.mode == wsd_pkg::M_MSET || r_reg.mode == wsd_pkg::M_HOLD) begin
            r_next.sec = 6'h00;
        end else if (qt && r_reg.q4 == 2'h3) begin
            sec_carry = (r_reg.sec == 6'h3b);
            r_next.sec = sec_carry ? 6'h00 : 6'(r_reg.sec + 6'h01);
        end
        // minutes: set steps never carry into hours
        min_carry = 1'b0;
        if (r_reg.mode == wsd_pkg::M_MSET) begin
            if (adv_min) begin
                r_next.min = (r_reg.min == 6'h3b) ? 6'h00 : 6'(r_reg.min + 6'h01);
            end
        end else if (sec_carry) begin
            min_carry = (r_reg.min == 6'h3b);
            r_next.min = min_carry ? 6'h00 : 6'(r_reg.min + 6'h01);
        end
        // hours 1..12 with am/pm, date carry only at pm to am
        hstep = hr_step(r_reg.hr, r_reg.pm);
        hr_carry = 1'b0;
        if (r_reg.mode == wsd_pkg::M_HSET) begin
            if (adv2) begin
                {r_next.pm, r_next.hr} = hstep;
            end
        end else if (min_carry) begin
            {r_next.pm, r_next.hr} = hstep;
            hr_carry = (r_reg.hr == 4'hb) && r_reg.pm;
        end
        // date 1..31, wraps to 1 both when set and when carried
        if ((r_reg.mode == wsd_pkg::M_DSET && adv2) || hr_carry) begin
            r_next.date = (r_reg.date == 5'h1f) ? 5'h01 : 5'(r_reg.date + 5'h01);
        end

        // display: digit slot is 8 ticks of 8192 Hz, so each step is 1/8
        hm_mode = (r_reg.mode == wsd_pkg::M_HM) || (r_reg.mode == wsd_pkg::M_HSET) ||
                  (r_reg.mode == wsd_pkg::M_MSET) || (r_reg.mode == wsd_pkg::M_HOLD);
        lbcd = 8'h00;
        rbcd = 8'h00;
        if (hm_mode) begin
            lbcd = to_bcd(6'(r_reg.hr));
            rbcd = to_bcd(r_reg.min);
        end else if (r_reg.mode == wsd_pkg::M_SEC) begin
            rbcd = to_bcd(r_reg.sec);
        end else begin
            lbcd = to_bcd(6'(r_reg.date));
        end
        dblank = 1'b0;
        case (r_reg.div[4:3])
            2'h0: begin
                dval = lbcd[7:4];
                dblank = (lbcd[7:4] == 4'h0) || (r_reg.mode == wsd_pkg::M_SEC);
            end
            2'h1: begin
                dval = lbcd[3:0];
                dblank = (r_reg.mode == wsd_pkg::M_SEC);
            end
            2'h2: begin
                dval = rbcd[7:4];
                dblank = (r_reg.mode == wsd_pkg::M_DATE) || (r_reg.mode == wsd_pkg::M_DSET);
            end
            default: begin
                dval = rbcd[3:0];
                dblank = (r_reg.mode == wsd_pkg::M_DATE) || (r_reg.mode == wsd_pkg::M_DSET);
            end
        endcase
        sg = dblank ? 7'h00 : seg7(dval);
        if (hm_mode && r_reg.div[4:3] == 2'h0 && !r_reg.pm) begin
            sg = sg | 7'h20;
        end
        // software override of the brightness pins; dim floats to 1 by pull-up
        bright = r_reg.ctrl[`WSD_CTRL_OVR_BIT] ?
                 r_reg.ctrl[`WSD_CTRL_SEL_LSB +: 2] : {dtcycl, dim};
        case (bright)
            2'h3: ontime = 3'h7;
            2'h2: ontime = 3'h2;
            2'h1: ontime = 3'h4;
            default: ontime = 3'h1;
        endcase
        visible = !((r_reg.mode == wsd_pkg::M_SEC || r_reg.mode == wsd_pkg::M_HOLD) &&
                    r_reg.q4 != 2'h0);
        // slot 7 is never lit, which doubles as inter-digit blanking
        active = (r_reg.mode != wsd_pkg::M_OFF) && visible && (r_reg.div[2:0] < ontime);
        r_next.disp.digit_en = active ? 4'(4'h1 << r_reg.div[4:3]) : 4'h0;
        r_next.disp.seg = !lamp_n ? 7'h7f : sg;
        r_next.disp.colon = active && (hm_mode || r_reg.mode == wsd_pkg::M_SEC);

        // apb: decode in setup, answer with zero wait states in access
        rd = 32'h0000_0000;
        rd[`WSD_TIME_SEC_LSB +: 6] = r_reg.sec;
        rd[`WSD_TIME_MIN_LSB +: 6] = r_reg.min;
        rd[`WSD_TIME_HR_LSB +: 4] = r_reg.hr;
        rd[`WSD_TIME_PM_BIT] = r_reg.pm;
        rd[`WSD_TIME_DATE_LSB +: 5] = r_reg.date;
        if (apb_req.psel && !apb_req.penable) begin
            r_next.pslverr = 1'b0;
            case (apb_req.paddr)
                `WSD_CTRL_OFS: r_next.prdata = {29'h0, r_reg.ctrl};
                `WSD_TIME_OFS: r_next.prdata = rd;
                `WSD_STAT_OFS: r_next.prdata = {25'h0, r_reg.mode, 2'h0, r_reg.db};
                default: begin
                    r_next.prdata = 32'h0000_0000;
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
            apb_req.paddr == `WSD_CTRL_OFS) begin
            r_next.ctrl = apb_req.pwdata[2:0];
        end
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pslverr = r_reg.pslverr;
    assign pready = apb_req.psel && apb_req.penable; // no wait states
    assign osc_tune_4096 = r_reg.div[0];
    assign tick_monitor_inject_pad_o = r_reg.div[10];
    assign tick_monitor_inject_pad_oe = test_n;
    assign disp = r_reg.disp;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pad_dir_test: assert property (!test_n |-> !tick_monitor_inject_pad_oe)
        else $error("pad driven while test input low");
    a_pad_inject_tick: assert property (!test_n && tick_monitor_inject_pad_i &&
        !r_reg.pad_prev |=> r_reg.q4 == 2'($past(r_reg.q4) + 2'h1))
        else $error("injected pad edge did not advance the quarter count");
    a_hold_sec_zero: assert property (r_reg.mode == wsd_pkg::M_HOLD |=> r_reg.sec == 6'h00)
        else $error("seconds not held at zero in hold");
    a_date_range: assert property (r_reg.date >= 5'h01 && r_reg.date <= 5'h1f)
        else $error("date out of range");
    a_hour_range: assert property (r_reg.hr >= 4'h1 && r_reg.hr <= 4'hc)
        else $error("hour out of range");
    a_digit_onehot: assert property ($onehot0(disp.digit_en))
        else $error("more than one digit enabled");
    a_lamp_all_on: assert property (##1 !$past(lamp_n) |-> disp.seg == 7'h7f)
        else $error("lamp test did not light all segments");
    a_min_no_carry: assert property (r_reg.mode == wsd_pkg::M_MSET && adv_min &&
        r_reg.min == 6'h3b |=> r_reg.min == 6'h00 && $stable(r_reg.hr))
        else $error("minute setting carried into hours");
    a_min_early_hold: assert property (r_reg.mode == wsd_pkg::M_MSET &&
        r_reg.both_q < MIN_Q |=> $stable(r_reg.min))
        else $error("minutes advanced before 0.75 s");
    a_debounce_wait: assert property ($changed(r_reg.db[0]) |->
        $past(r_reg.dcnt[0]) == DEB_LAST)
        else $error("display switch accepted before debounce time");
    a_dim_slot_off: assert property (r_reg.div[2:0] >= ontime |=> disp.digit_en == 4'h0)
        else $error("digit lit outside its on-time");

endmodule

// File: wsd_user_model.sv
// push-button model for the display and set switches, with contact bounce
module wsd_user_model (
    input wire logic pclk,
    output logic disp_sw,
    output logic set_sw
);
    timeunit 1ns;
    timeprecision 1ps;

    // both switches normally open at power-up
    initial begin
        disp_sw = 1'b0;
        set_sw = 1'b0;
    end

    // one switch line, selected by sel (1 = set, 0 = display)
    task automatic drive(input logic sel, input logic v);
        if (sel) begin
            set_sw <= v;
        end else begin
            disp_sw <= v;
        end
    endtask

    // chatter 40 cycles apart, settled well inside the debounce window
    task automatic press(input logic sel, input logic lvl);
        for (int i = 0; i < 7; i++) begin
            drive(sel, lvl ^ i[0]);
            repeat (40) @(posedge pclk);
        end
        repeat (800) @(posedge pclk);
    endtask

    // short spike that a debounced input must ignore
    task automatic glitch(input logic sel);
        drive(sel, 1'b1);
        repeat (100) @(posedge pclk);
        drive(sel, 1'b0);
        repeat (800) @(posedge pclk);
    endtask
endmodule

// File: testbench.sv
// self-checking bench for the watch display and time-setting control
`include "wsd_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wsd_pkg::wsd_apb_req_t req = '0;
    logic [31:0] prdata, t, s, d;
    logic pready, pslverr, disp_sw, set_sw, pad_o, pad_oe, osc, e, pad;
    logic dtcycl = 1'b1, dim = 1'b1, lamp_n = 1'b1, test_n = 1'b1, pad_drv = 1'b0;
    wsd_pkg::wsd_disp_t disp;
    int error_cnt = 0, n_tests = 0, cyc = 0;

    always #4 pclk = ~pclk;
    // shared test pad level: device drives it only while enabled
    assign pad = pad_oe ? pad_o : pad_drv;

    wsd_watch_ctrl #(.TICK_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .disp_sw(disp_sw),
        .set_sw(set_sw), .dtcycl(dtcycl), .dim(dim), .lamp_n(lamp_n), .test_n(test_n),
        .tick_monitor_inject_pad_i(pad), .tick_monitor_inject_pad_o(pad_o),
        .tick_monitor_inject_pad_oe(pad_oe), .osc_tune_4096(osc), .disp(disp));
    wsd_user_model partner_u (.pclk(pclk), .disp_sw(disp_sw), .set_sw(set_sw));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready as long as the slave takes
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        // only the bench timeout bounds a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdt;
        apb(1'b0, `WSD_TIME_OFS, 32'h0, t, e);
    endtask

    task automatic mode_is(input wsd_pkg::wsd_mode_t m);
        apb(1'b0, `WSD_STAT_OFS, 32'h0, s, e);
        chk(32'(s[6:4]), 32'(m));
    endtask

    // each rising pad edge stands for one quarter-second tick
    task automatic qtick(input int n);
        repeat (n) begin
            pad_drv <= 1'b1;
            repeat (4) @(posedge pclk);
            pad_drv <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask

    task automatic lit(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge pclk);
            if (disp.digit_en !== 4'h0) c++;
        end
    endtask

    // length of one digit-4 on-time, from a fresh slot
    task automatic run(output int c, output int bad);
        int n;
        n = 0;
        c = 0;
        bad = 0;
        while (disp.digit_en !== 4'h4 && n < 300) begin @(posedge pclk); n++; end
        while (disp.digit_en !== 4'h8 && n < 300) begin @(posedge pclk); n++; end
        while (disp.digit_en === 4'h8 && c < 300) begin
            if (disp.seg !== 7'h7f) bad |= 1;
            if (disp.colon !== 1'b1) bad |= 2;
            @(posedge pclk);
            c++;
        end
    endtask

    task automatic t_regs;
        rdt;
        chk(t, 32'h010c0000);
        chk(32'(disp), 32'h0);
        apb(1'b1, `WSD_CTRL_OFS, 32'h7, d, e);
        apb(1'b0, `WSD_CTRL_OFS, 32'h0, d, e);
        chk(d, 32'h7);
        apb(1'b1, `WSD_CTRL_OFS, 32'h0, d, e);
        apb(1'b1, `WSD_TIME_OFS, 32'hffffffff, d, e);
        rdt;
        chk(t, 32'h010c0000);
        apb(1'b0, 12'h00c, 32'h0, d, e);
        chk(32'(e), 32'h1);
        chk(d, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_tune;
        int h;
        chk(32'(pad_oe), 32'h1);
        h = 0;
        repeat (64) begin @(posedge pclk); h += osc; end
        chk(h, 32);
        h = 0;
        repeat (8192) begin @(posedge pclk); h += pad_o; end
        chk(h, 4096);
        test_n <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(pad_oe), 32'h0);
        $display("test tune done");
    endtask

    task automatic t_date;
        int w;
        logic [4:0] p;
        partner_u.press(1'b0, 1'b1);
        mode_is(wsd_pkg::M_HM);
        partner_u.press(1'b0, 1'b0);
        partner_u.press(1'b0, 1'b1);
        mode_is(wsd_pkg::M_DATE);
        qtick(8);
        mode_is(wsd_pkg::M_DATE);
        partner_u.press(1'b1, 1'b1);
        mode_is(wsd_pkg::M_DSET);
        w = 0;
        p = 5'h01;
        for (int i = 0; i < 40; i++) begin
            qtick(2);
            rdt;
            chk(32'(t[28:24] != 5'h00), 32'h1);
            chk(32'(t[19:16]), 32'hc);
            if (p == 5'h1f && t[28:24] == 5'h01) w = 1;
            p = t[28:24];
        end
        chk(w, 1);
        chk(32'(t[5:0] != 6'h00), 32'h1);
        partner_u.press(1'b1, 1'b0);
        partner_u.press(1'b0, 1'b0);
        qtick(8);
        mode_is(wsd_pkg::M_OFF);
        // look while the spike still stands: it must not reach the debounced level
        fork
            partner_u.glitch(1'b1);
            begin
                repeat (90) @(posedge pclk);
                mode_is(wsd_pkg::M_OFF);
            end
        join
        mode_is(wsd_pkg::M_OFF);
        chk(32'(s[1:0]), 32'h0);
        $display("test date done");
    endtask

    task automatic t_hour;
        int w;
        logic [4:0] d0;
        rdt;
        d0 = t[28:24];
        partner_u.press(1'b1, 1'b1);
        mode_is(wsd_pkg::M_HSET);
        w = 0;
        for (int i = 0; i < 30; i++) begin
            qtick(2);
            rdt;
            chk(32'(t[19:16] >= 4'h1 && t[19:16] <= 4'hc), 32'h1);
            chk(32'(t[28:24]), 32'(d0));
            if (t[19:16] == 4'h1) w = 1;
        end
        chk(w, 1);
        partner_u.press(1'b1, 1'b0);
        qtick(8);
        $display("test hour done");
    endtask

    task automatic t_duty;
        int c, bad;
        int on[4] = '{1, 4, 2, 7};
        partner_u.press(1'b0, 1'b1);
        mode_is(wsd_pkg::M_HM);
        // 6 am after hour setting: tens blanked, am mark alone on digit 1
        while (disp.digit_en !== 4'h1) @(posedge pclk);
        chk(32'(disp.seg), 32'h20);
        for (int i = 0; i < 4; i++) begin
            {dtcycl, dim} <= 2'(i);
            repeat (40) @(posedge pclk);
            run(c, bad);
            chk(c, on[i] * 4);
            chk(bad & 2, 0);
        end
        lamp_n <= 1'b0;
        repeat (40) @(posedge pclk);
        run(c, bad);
        chk(bad, 0);
        chk(c, 28);
        lamp_n <= 1'b1;
        $display("test duty done");
    endtask

    task automatic t_min;
        int w, c, on;
        logic [5:0] m0;
        logic [3:0] h0;
        rdt;
        m0 = t[13:8];
        partner_u.press(1'b1, 1'b1);
        qtick(2);
        partner_u.press(1'b1, 1'b0);
        rdt;
        chk(32'(t[5:0]), 32'h0);
        chk(32'(t[13:8]), 32'(m0));
        mode_is(wsd_pkg::M_HOLD);
        partner_u.press(1'b1, 1'b1);
        mode_is(wsd_pkg::M_MSET);
        rdt;
        m0 = t[13:8];
        h0 = t[19:16];
        qtick(3);
        rdt;
        chk(32'(t[13:8]), 32'(m0));
        chk(32'(t[5:0]), 32'h0);
        qtick(1);
        rdt;
        chk(32'(t[13:8]), (32'(m0) + 1) % 60);
        w = 0;
        for (int i = 0; i < 62; i++) begin
            qtick(2);
            rdt;
            chk(32'(t[19:16]), 32'(h0));
            if (t[13:8] == 6'h00) w = 1;
        end
        chk(w, 1);
        partner_u.press(1'b1, 1'b0);
        mode_is(wsd_pkg::M_HOLD);
        on = 0;
        for (int i = 0; i < 4; i++) begin
            qtick(1);
            lit(128, c);
            if (c > 0) on++;
            rdt;
            chk(32'(t[5:0]), 32'h0);
        end
        chk(on, 1);
        partner_u.press(1'b0, 1'b0);
        qtick(8);
        rdt;
        chk(32'(t[5:0] != 6'h00), 32'h1);
        mode_is(wsd_pkg::M_OFF);
        $display("test minute done");
    endtask

    // cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_tune();
        t_date();
        t_hour();
        t_duty();
        t_min();
        complete_run();
    end
endmodule
